/* hw/scan_engine_mode_sequencer.sv */
// operating mode sequencer of the linear scan engine
`timescale 1ns/10ps
`default_nettype none
module scan_engine_mode_sequencer #(
	parameter int MS_CYC        = seq_pkg::MS_CYC,
	parameter int TRIG_HOLD_CYC = seq_pkg::TRIG_HOLD_CYC,
	parameter int WAKE_HOLD_CYC = seq_pkg::WAKE_HOLD_CYC,
	parameter int TONE_HALF_CYC = seq_pkg::TONE_HALF_CYC
) (
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_rstn,
	// host pins
	input  wire logic              i_trigger_n,
	input  wire logic              i_wake_n,
	// decoder core
	input  wire logic              i_decode_ok,
	input  wire seq_pkg::idle_type i_idle_ms,
	// status and drive
	output logic                   o_beeper,
	output logic                   o_idle,
	output logic                   o_illum,
	output logic                   o_tx_active,
	output logic                   o_standby,
	output logic                   o_fw_update
);

	localparam seq_pkg::ms_div_type MS_LAST =
		seq_pkg::ms_div_type'(MS_CYC - 1);
	localparam seq_pkg::tone_type TONE_LAST =
		seq_pkg::tone_type'(TONE_HALF_CYC - 1);

	seq_pkg::seq_regs_type r, n;
	logic trig_low;
	logic trig_held;
	logic trig_wake;
	logic wake_low;
	logic wake_held;
	logic ms_tick;

	////////////////////////////////////////////////////////////////////////
	// pin qualifiers
	seq_pin_filter #(.HOLD_CYC(TRIG_HOLD_CYC)) u_trig (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_pin_n   (i_trigger_n),
		.o_low     (trig_low),
		.o_held    (trig_held)
	);

	seq_pin_filter #(.HOLD_CYC(WAKE_HOLD_CYC)) u_trig_wake (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_pin_n   (i_trigger_n),
		.o_low     (),
		.o_held    (trig_wake)
	);

	seq_pin_filter #(.HOLD_CYC(WAKE_HOLD_CYC)) u_wake (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_pin_n   (i_wake_n),
		.o_low     (wake_low),
		.o_held    (wake_held)
	);

	////////////////////////////////////////////////////////////////////////
	// state entry restarts phase timers and the tone high
	function automatic seq_pkg::seq_regs_type enter(
		input seq_pkg::seq_regs_type s,
		input seq_pkg::seq_state_type st
	);
		seq_pkg::seq_regs_type t;
		t = s;
		t.state    = st;
		t.ms_div   = '0;
		t.ms_cnt   = '0;
		t.idle_cnt = '0;
		t.tone_cnt = '0;
		t.tone     = 1'b1;
		return t;
	endfunction : enter

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		ms_tick = (r.ms_div == MS_LAST);
		n.ms_div = ms_tick ? '0 : r.ms_div + 1'b1;
		if (ms_tick && (r.ms_cnt != '1)) begin
			n.ms_cnt = r.ms_cnt + 1'b1;
		end
		// beeper carrier
		if (r.tone_cnt == TONE_LAST) begin
			n.tone_cnt = '0;
			n.tone = !r.tone;
		end else begin
			n.tone_cnt = r.tone_cnt + 1'b1;
		end
		n.trig_prev = trig_low;
		case (r.state)
			seq_pkg::ST_INIT: begin
				if (ms_tick && (r.ms_cnt == seq_pkg::INIT_LAST)) begin
					n = enter(n, trig_low ? seq_pkg::ST_FWUPD
					                      : seq_pkg::ST_PUBEEP);
				end
			end
			seq_pkg::ST_PUBEEP: begin
				if (ms_tick && (r.ms_cnt == seq_pkg::PUBEEP_LAST)) begin
					n = enter(n, seq_pkg::ST_STANDBY);
				end
			end
			seq_pkg::ST_STANDBY: begin
				if (trig_low && !r.trig_prev) begin
					n = enter(n, seq_pkg::ST_SCAN);
				end else if (trig_low || wake_low) begin
					n.idle_cnt = '0;
				end else if (ms_tick && (i_idle_ms != '0)) begin
					if (r.idle_cnt >= i_idle_ms - 1'b1) begin
						n = enter(n, seq_pkg::ST_SLEEP);
					end else begin
						n.idle_cnt = r.idle_cnt + 1'b1;
					end
				end
			end
			seq_pkg::ST_SCAN: begin
				if (!trig_low) begin
					n = enter(n, seq_pkg::ST_STANDBY);
				end else if (i_decode_ok && trig_held) begin
					n = enter(n, seq_pkg::ST_GOOD);
				end
			end
			seq_pkg::ST_GOOD: begin
				if (ms_tick && (r.ms_cnt == seq_pkg::XFER_LAST)) begin
					n = enter(n, seq_pkg::ST_STANDBY);
				end
			end
			seq_pkg::ST_SLEEP: begin
				if (trig_wake) begin
					n = enter(n, seq_pkg::ST_SCAN);
				end else if (wake_held) begin
					n = enter(n, seq_pkg::ST_STANDBY);
				end
			end
			seq_pkg::ST_FWUPD: begin
				n.state = seq_pkg::ST_FWUPD;
			end
			default: begin
				n = enter(n, seq_pkg::ST_INIT);
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			r <= seq_pkg::SEQ_RESET;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_beeper    = r.tone && ((r.state == seq_pkg::ST_PUBEEP) ||
	                     (r.state == seq_pkg::ST_GOOD));
	assign o_idle      = (r.state == seq_pkg::ST_SLEEP);
	assign o_illum     = (r.state == seq_pkg::ST_SCAN);
	assign o_tx_active = (r.state == seq_pkg::ST_GOOD);
	assign o_standby   = (r.state == seq_pkg::ST_STANDBY);
	assign o_fw_update = (r.state == seq_pkg::ST_FWUPD);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	a_init_bound: assert property (
		(r.state == seq_pkg::ST_INIT) |-> (r.ms_cnt <= seq_pkg::INIT_LAST))
		else $error("init phase overran");
	a_init_exit: assert property (
		($past(r.state) == seq_pkg::ST_INIT) && (r.state != seq_pkg::ST_INIT)
		|-> (o_beeper || o_fw_update))
		else $error("init did not end in beep or update");
	a_sleep_entry: assert property (
		$rose(o_idle) |-> ($past(r.state) == seq_pkg::ST_STANDBY)
		&& ($past(r.idle_cnt) >= $past(i_idle_ms) - 16'h0001))
		else $error("sleep entered before idle period");
	a_rearm_needed: assert property (
		(r.state == seq_pkg::ST_STANDBY) && trig_low && r.trig_prev
		|=> (r.state != seq_pkg::ST_SCAN))
		else $error("scan restarted without release");
	a_release_abort: assert property (
		(r.state == seq_pkg::ST_SCAN) && !trig_low
		|=> (r.state == seq_pkg::ST_STANDBY))
		else $error("scan kept after trigger release");
	a_beep_on_decode: assert property (
		(r.state == seq_pkg::ST_SCAN) && trig_low && trig_held && i_decode_ok
		|=> o_beeper && o_tx_active && !o_illum)
		else $error("good read did not raise beeper");
	a_xfer_bound: assert property (
		o_tx_active |-> (r.ms_cnt <= seq_pkg::XFER_LAST))
		else $error("transfer phase overran");
	a_wake_standby: assert property (
		(r.state == seq_pkg::ST_SLEEP) && wake_held && !trig_wake
		|=> o_standby && !o_idle)
		else $error("wake did not return to standby");
	a_trig_wake: assert property (
		(r.state == seq_pkg::ST_SLEEP) && trig_wake |=> o_illum)
		else $error("trigger did not wake into scan");
	a_fw_sticky: assert property (
		o_fw_update |=> o_fw_update && !o_beeper)
		else $error("update mode left");
	a_beep_source: assert property (
		o_beeper |-> ((r.state == seq_pkg::ST_PUBEEP) || o_tx_active))
		else $error("beeper active outside beep phases");

	c_powerup_beep: cover property ((r.state == seq_pkg::ST_PUBEEP) ##1 o_standby);
	c_good_read:    cover property (o_illum ##1 o_tx_active);
	c_sleep_wake:   cover property (o_idle ##1 o_standby);
	c_fw_update:    cover property ($rose(o_fw_update));

endmodule : scan_engine_mode_sequencer
`default_nettype wire

/* hw/seq_pkg.sv */
// constants and types of the scan engine mode sequencer
package seq_pkg;

	// clock and times
	localparam int CLK_HZ        = 25_000_000;
	localparam int MS_CYC        = CLK_HZ / 1000;
	localparam int INIT_MS       = 10;
	localparam int TRIG_HOLD_MS  = 20;
	localparam int WAKE_HOLD_MS  = 2;
	localparam int XFER_MS       = 80;
	localparam int PUBEEP_MS     = 80;
	localparam int SCAN_MAX_MS   = 120;
	localparam int TONE_HZ       = 2700;
	localparam int TRIG_HOLD_CYC = TRIG_HOLD_MS * MS_CYC;
	localparam int WAKE_HOLD_CYC = WAKE_HOLD_MS * MS_CYC;
	localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);

	// counter types
	typedef logic [14:0] ms_div_type;
	typedef logic [7:0]  ms_cnt_type;
	typedef logic [15:0] idle_type;
	typedef logic [15:0] tone_type;
	typedef logic [19:0] filt_cnt_type;

	// millisecond tick counts, last tick of each phase
	localparam ms_cnt_type INIT_LAST   = ms_cnt_type'(INIT_MS - 1);
	localparam ms_cnt_type PUBEEP_LAST = ms_cnt_type'(PUBEEP_MS - 1);
	localparam ms_cnt_type XFER_LAST   = ms_cnt_type'(XFER_MS - 1);

	typedef enum logic [2:0] {
		ST_INIT    = 3'h0,
		ST_PUBEEP  = 3'h1,
		ST_STANDBY = 3'h2,
		ST_SCAN    = 3'h3,
		ST_GOOD    = 3'h4,
		ST_SLEEP   = 3'h5,
		ST_FWUPD   = 3'h6
	} seq_state_type;

	typedef struct packed {
		seq_state_type state;
		ms_div_type    ms_div;
		ms_cnt_type    ms_cnt;
		idle_type      idle_cnt;
		tone_type      tone_cnt;
		logic          tone;
		logic          trig_prev;
	} seq_regs_type;

	typedef struct packed {
		logic [1:0]   sync;
		filt_cnt_type cnt;
	} filt_regs_type;

	localparam seq_regs_type SEQ_RESET = '{
		state:     ST_INIT,
		ms_div:    15'h0000,
		ms_cnt:    8'h00,
		idle_cnt:  16'h0000,
		tone_cnt:  16'h0000,
		tone:      1'h0,
		trig_prev: 1'h0
	};

	localparam filt_regs_type FILT_RESET = '{
		sync: 2'h3,
		cnt:  20'h00000
	};

endpackage : seq_pkg

/* hw/seq_pin_filter.sv */
// pin synchroniser with minimum low-time qualifier
`timescale 1ns/10ps
`default_nettype none
module seq_pin_filter #(
	parameter int HOLD_CYC = 2
) (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	// pin, active low
	input  wire logic i_pin_n,
	// qualified levels
	output logic      o_low,
	output logic      o_held
);

	localparam seq_pkg::filt_cnt_type HOLD_LAST =
		seq_pkg::filt_cnt_type'(HOLD_CYC - 1);

	seq_pkg::filt_regs_type r, n;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		n.sync = {r.sync[0], i_pin_n};
		if (r.sync[1]) begin
			n.cnt = '0;
		end else if (r.cnt != HOLD_LAST) begin
			n.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			r <= seq_pkg::FILT_RESET;
		end else begin
			r <= n;
		end
	end

	assign o_low  = !r.sync[1];
	assign o_held = !r.sync[1] && (r.cnt == HOLD_LAST);

	////////////////////////////////////////////////////////////////////////
	a_held_is_low: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_held |-> o_low && $past(o_low))
		else $error("held without sustained low");
	a_release_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!o_low |=> !o_held)
		else $error("held survived a release");

endmodule : seq_pin_filter
`default_nettype wire

/* dv/host_model.sv */
// host controller model driving the trigger and wake pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// clock
	input  wire logic i_clk_sys,
	// pins, released to the pull-up level
	output var logic  o_trigger_n,
	output var logic  o_wake_n
);
	initial begin
		o_trigger_n = 1'b1;
		o_wake_n    = 1'b1;
	end
	// press or release the trigger at the next edge
	task automatic set_trig(input logic low);
		@(posedge i_clk_sys);
		o_trigger_n <= ~low;
	endtask : set_trig
	// wake pulse of n cycles
	task automatic pulse_wake(input int n);
		@(posedge i_clk_sys);
		o_wake_n <= 1'b0;
		repeat (n) @(posedge i_clk_sys);
		o_wake_n <= 1'b1;
	endtask : pulse_wake
endmodule : host_model
`default_nettype wire

/* dv/tb_scan_engine_mode_sequencer.sv */
// self-checking bench of the mode sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_scan_engine_mode_sequencer;
	localparam int MS = 20;
	localparam int TH = 40;
	localparam int WH = 8;
	localparam int TN = 3;
	logic              i_clk_sys, i_rstn, i_decode_ok;
	seq_pkg::idle_type i_idle_ms;
	wire logic         trig_n, wake_n;
	logic              o_beeper, o_idle, o_illum;
	logic              o_tx_active, o_standby, o_fw_update;
	int                failures, n_compared, n, t, b, cyc;
	logic              p;
	localparam int W_BEEP = 0, W_IDLE = 1, W_ILLUM = 2, W_TX = 3, W_STBY = 4;
	// free-running edge count for interval checks
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
	end
	host_model host (.i_clk_sys(i_clk_sys), .o_trigger_n(trig_n),
		.o_wake_n(wake_n));
	scan_engine_mode_sequencer #(.MS_CYC(MS), .TRIG_HOLD_CYC(TH),
		.WAKE_HOLD_CYC(WH), .TONE_HALF_CYC(TN)) uut (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_trigger_n(trig_n),
		.i_wake_n(wake_n), .i_decode_ok(i_decode_ok),
		.i_idle_ms(i_idle_ms), .o_beeper(o_beeper), .o_idle(o_idle),
		.o_illum(o_illum), .o_tx_active(o_tx_active),
		.o_standby(o_standby), .o_fw_update(o_fw_update));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : chk
	task automatic tk(input int c);
		repeat (c) @(posedge i_clk_sys);
		#1;
	endtask : tk
	function automatic logic pick(input int k);
		case (k)
			W_BEEP:  return o_beeper;
			W_IDLE:  return o_idle;
			W_ILLUM: return o_illum;
			W_TX:    return o_tx_active;
			default: return o_standby;
		endcase
	endfunction : pick
	// n ends as the edge count at which the level was first seen
	task automatic wait_lvl(input int k, input logic v, input int lim);
		tk(1);
		n = 1;
		while (pick(k) !== v && n < lim) begin
			tk(1);
			n++;
		end
	endtask : wait_lvl
	task automatic pulse_dec();
		@(posedge i_clk_sys);
		i_decode_ok <= 1'b1;
		@(posedge i_clk_sys);
		i_decode_ok <= 1'b0;
		#1;
	endtask : pulse_dec
	task automatic do_reset(input logic trig_low);
		host.set_trig(trig_low);
		i_rstn <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		tk(1);
		chk("standby in init", 1'b0, o_standby);
		chk("beep in init", 1'b0, o_beeper);
		chk("update in init", 1'b0, o_fw_update);
	endtask : do_reset
	////////////////////////////////////////////////////////////////////
	task automatic t_fwupd();
		do_reset(1'b1);
		tk(260);
		chk("fw update", 1'b1, o_fw_update);
		chk("standby fw", 1'b0, o_standby);
		host.set_trig(1'b0);
		tk(20);
		chk("fw sticky", 1'b1, o_fw_update);
		chk("fw silent", 1'b0, o_beeper);
	endtask : t_fwupd
	task automatic t_powerup();
		do_reset(1'b0);
		wait_lvl(W_BEEP, 1'b1, 260);
		chk("init time", 1'b1, n >= 10 * MS - 10 && n <= 10 * MS);
		wait_lvl(W_STBY, 1'b1, 1700);
		chk("beep time", 1'b1, n >= 1590 && n <= 1610);
		chk("beep off", 1'b0, o_beeper);
	endtask : t_powerup
	task automatic t_scan();
		host.set_trig(1'b1);
		wait_lvl(W_ILLUM, 1'b1, 6);
		t = cyc - n;
		chk("illum on", 1'b1, o_illum);
		pulse_dec();
		chk("early decode", 1'b0, o_tx_active);
		chk("still scanning", 1'b1, o_illum);
		tk(TH);
		pulse_dec();
		chk("tx on", 1'b1, o_tx_active);
		chk("illum off", 1'b0, o_illum);
		chk("beep on", 1'b1, o_beeper);
		b = cyc;
		p = o_beeper;
		n = 0;
		for (int i = 0; i < 4 * TN; i++) begin
			tk(1);
			if (o_beeper !== p) begin
				n++;
			end
			p = o_beeper;
		end
		chk("tone", 1'b1, n == 4);
		wait_lvl(W_TX, 1'b0, 1700);
		n = cyc - b;
		chk("xfer", 1'b1, n >= 79 * MS && n <= 81 * MS);
		chk("total", 1'b1, cyc - t <= 120 * MS);
		chk("beep end", 1'b0, o_beeper);
		tk(5);
		chk("no rescan", 1'b0, o_illum);
		host.set_trig(1'b0);
		tk(5);
		host.set_trig(1'b1);
		wait_lvl(W_ILLUM, 1'b1, 6);
		chk("rescan", 1'b1, o_illum);
		host.set_trig(1'b0);
		wait_lvl(W_ILLUM, 1'b0, 6);
		chk("release", 1'b1, o_standby);
	endtask : t_scan
	task automatic t_sleep();
		@(posedge i_clk_sys);
		i_idle_ms <= 16'h0002;
		wait_lvl(W_IDLE, 1'b1, 60);
		chk("sleep", 1'b0, o_standby);
		host.pulse_wake(4);
		tk(WH);
		chk("short wake", 1'b1, o_idle);
		b = cyc;
		host.pulse_wake(WH + 2);
		wait_lvl(W_STBY, 1'b1, 4);
		chk("woken", 1'b0, o_idle);
		chk("wake time", 1'b1, cyc - b <= 2 * MS);
		wait_lvl(W_IDLE, 1'b1, 60);
		chk("idle time", 1'b1, n >= 35 && n <= 45);
		b = cyc;
		host.set_trig(1'b1);
		wait_lvl(W_ILLUM, 1'b1, WH + 8);
		chk("trig wake", 1'b0, o_idle);
		chk("trig scan", 1'b1, o_illum);
		tk(TH);
		pulse_dec();
		chk("sleep decode", 1'b1, o_tx_active);
		host.set_trig(1'b0);
		i_idle_ms <= 16'h0000;
		wait_lvl(W_TX, 1'b0, 1700);
		chk("sleep total", 1'b1, cyc - b <= 120 * MS);
	endtask : t_sleep
	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_rstn      = 1'b0;
		i_decode_ok = 1'b0;
		i_idle_ms   = 16'h0000;
		failures    = 0;
		n_compared  = 0;
		t_fwupd();
		t_powerup();
		t_scan();
		t_sleep();
		end_sim();
	end
	initial begin
		#(40 * 20000);
		failures++;
		end_sim();
	end
endmodule : tb_scan_engine_mode_sequencer
`default_nettype wire
